// File: core/byte_fifo.sv
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: Filling and draining run on the same clock.
// Notes: Full and empty come from pointers with one extra wrap bit.
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } fifo_state_t;

  fifo_state_t r;
  fifo_state_t n;
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic do_push;
  logic do_pop;

  assign out_valid = (r.wptr != r.rptr);
  assign in_ready = (r.wptr[AW-1:0] != r.rptr[AW-1:0]) || (r.wptr[AW] == r.rptr[AW]);
  assign out_data = store[r.rptr[AW-1:0]];
  assign do_push = ce && in_valid && in_ready;
  assign do_pop = ce && out_ready && out_valid;

  always_comb begin
    n = r;
    if (do_push) begin
      n.wptr = AW'(1) + r.wptr;
    end
    if (do_pop) begin
      n.rptr = AW'(1) + r.rptr;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  // Storage carries no reset; only the pointers need a defined value.
  always_ff @(posedge clk) begin
    if (do_push) begin
      store[r.wptr[AW-1:0]] <= in_data;
    end
  end

endmodule

// File: core/two_wire_eeprom_slave.sv
// Purpose: Slave logic of a 256-byte serial memory on a two-wire bus.
// Assumes: The bus clock and data are sampled by ref_clk, well above bus rate.
// Notes: Received write bytes queue in a FIFO and enter the array during programming, which Stop starts.
`timescale 1ns/1ps

// Operation
// R1: Array of 256 bytes, eight-bit address, sixteen-byte pages.
// R2: Full or partial page writes; only received bytes change.
// R3: Self-timed programming after the write ends, within five milliseconds.
// R4: Reset ignores the bus, clears the machine and leaves it in standby.
// R5: Stop returns to standby, or after programming when one runs.
// R6: Three select inputs must match the address byte; floating reads zero.
// R7: Write protect high blocks every array change.
// R8: Write protect low or floating allows normal writes.
// R9: Data line is open drain, shared by addresses and data.
// R10: Master sends select byte, word address, then data bytes.
// R11: Master makes the bus clock; every bit follows its edges.
// R12: Data falling with clock high is Start, rising is Stop.
// R13: Select byte is type, select bits, direction; acknowledged on ninth clock.
// R14: Page write wraps the low four address bits within the page.
// R15: No acknowledge at all while programming runs.
module two_wire_eeprom_slave #(
  parameter logic [3:0] DEV_TYPE = 4'h5,
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // Two-wire bus
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Strap pins
  input wire logic device_select_bit_0,
  input wire logic device_select_bit_1,
  input wire logic device_select_bit_2,
  input wire logic write_protect,
  // Status
  output logic busy
);
  // DEV_TYPE default is arbitrary.

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    eeprom_pkg::bus_state_t st;
    logic scl_s1;
    logic scl_s2;
    logic scl_q;
    logic sda_s1;
    logic sda_s2;
    logic sda_q;
    logic [2:0] sel_s1;
    logic [2:0] sel_s2;
    logic wp_s1;
    logic wp_s2;
    logic [eeprom_pkg::DATA_W-1:0] shift;
    logic [3:0] bitcnt;
    logic [eeprom_pkg::ADDR_W-1:0] addr;
    logic rw;
    logic mack;
    logic drive_low;
    logic sda_o;
    logic busy;
    logic [eeprom_pkg::PROG_CNT_W-1:0] prog_cnt;
  } slave_state_t;

  slave_state_t r;
  slave_state_t n;

  // R1: storage array
  logic [eeprom_pkg::DATA_W-1:0] mem [0:eeprom_pkg::MEM_BYTES-1];

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic push_c;
  logic drain_c;
  logic fifo_in_ready;
  logic fifo_out_valid;
  eeprom_pkg::wr_item_t fifo_in;
  eeprom_pkg::wr_item_t fifo_out;
  logic [eeprom_pkg::DATA_W-1:0] rd_byte;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // R14: page wrap increment
  function automatic logic [eeprom_pkg::ADDR_W-1:0] page_inc(
    input logic [eeprom_pkg::ADDR_W-1:0] a
  );
    logic [eeprom_pkg::PAGE_W-1:0] low;
    low = a[eeprom_pkg::PAGE_W-1:0] + eeprom_pkg::PAGE_W'(1);
    return {a[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W], low};
  endfunction

  function automatic logic [eeprom_pkg::ADDR_W-1:0] seq_inc(
    input logic [eeprom_pkg::ADDR_W-1:0] a
  );
    return a + eeprom_pkg::ADDR_W'(1);
  endfunction

  // R11: edges of the master clock
  assign scl_rise = r.scl_s2 && !r.scl_q;
  assign scl_fall = !r.scl_s2 && r.scl_q;
  // R12: Start and Stop detection
  assign start_c = r.scl_s2 && r.scl_q && r.sda_q && !r.sda_s2;
  assign stop_c = r.scl_s2 && r.scl_q && !r.sda_q && r.sda_s2;

  assign rd_byte = mem[r.addr];
  assign fifo_in = '{addr: r.addr, data: r.shift};
  // R3: drain only while programming
  assign drain_c = (r.st == eeprom_pkg::ST_PROG);

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    n = r;
    push_c = 1'b0;
    n.scl_s1 = scl;
    n.scl_s2 = r.scl_s1;
    n.scl_q = r.scl_s2;
    n.sda_s1 = sda_in;
    n.sda_s2 = r.sda_s1;
    n.sda_q = r.sda_s2;
    n.sel_s1 = {device_select_bit_2, device_select_bit_1, device_select_bit_0};
    n.sel_s2 = r.sel_s1;
    n.wp_s1 = write_protect;
    n.wp_s2 = r.wp_s1;
    n.sda_o = 1'b0;
    if (r.st == eeprom_pkg::ST_PROG) begin
      // R15: bus ignored while busy
      n.drive_low = 1'b0;
      n.prog_cnt = r.prog_cnt + eeprom_pkg::PROG_CNT_W'(1);
      // R5: standby after the cycle
      if (r.prog_cnt >= eeprom_pkg::PROG_CNT_W'(PROG_CYCLES - 1) && !fifo_out_valid) begin
        n.st = eeprom_pkg::ST_IDLE;
        n.busy = 1'b0;
      end
    end else if (start_c) begin
      n.st = eeprom_pkg::ST_DEV_ADDR;
      n.bitcnt = '0;
      n.drive_low = 1'b0;
    end else if (stop_c) begin
      n.drive_low = 1'b0;
      // R5: Stop ends the transfer
      if (fifo_out_valid) begin
        n.st = eeprom_pkg::ST_PROG;
        n.busy = 1'b1;
        n.prog_cnt = '0;
      end else begin
        n.st = eeprom_pkg::ST_IDLE;
      end
    end else if (scl_rise) begin
      case (r.st)
        eeprom_pkg::ST_DEV_ADDR, eeprom_pkg::ST_WORD_ADDR, eeprom_pkg::ST_WR_DATA,
        eeprom_pkg::ST_RD_DATA: begin
          // R11: one bit per clock pulse
          n.shift = {r.shift[6:0], r.sda_s2};
          n.bitcnt = r.bitcnt + 4'h1;
        end
        eeprom_pkg::ST_RD_ACK: begin
          n.mack = !r.sda_s2;
        end
        default: begin
          n.st = r.st;
        end
      endcase
    end else if (scl_fall) begin
      case (r.st)
        eeprom_pkg::ST_DEV_ADDR: begin
          if (r.bitcnt == eeprom_pkg::BITS_PER_BYTE) begin
            // R6: select pins match
            // R13: type, select, direction
            if (r.shift[7:4] == DEV_TYPE && r.shift[3:1] == r.sel_s2) begin
              n.rw = r.shift[0];
              n.drive_low = 1'b1;
              n.st = eeprom_pkg::ST_ACK_DEV;
            end else begin
              n.st = eeprom_pkg::ST_IDLE;
            end
          end
        end
        eeprom_pkg::ST_ACK_DEV: begin
          n.bitcnt = '0;
          if (r.rw) begin
            n.shift = rd_byte;
            n.addr = seq_inc(r.addr);
            n.drive_low = !rd_byte[7];
            n.st = eeprom_pkg::ST_RD_DATA;
          end else begin
            n.drive_low = 1'b0;
            n.st = eeprom_pkg::ST_WORD_ADDR;
          end
        end
        eeprom_pkg::ST_WORD_ADDR: begin
          if (r.bitcnt == eeprom_pkg::BITS_PER_BYTE) begin
            // R10: word address follows select byte
            n.addr = r.shift;
            n.drive_low = 1'b1;
            n.st = eeprom_pkg::ST_ACK_WORD;
          end
        end
        eeprom_pkg::ST_ACK_WORD, eeprom_pkg::ST_ACK_DATA: begin
          n.bitcnt = '0;
          n.drive_low = 1'b0;
          n.st = eeprom_pkg::ST_WR_DATA;
        end
        eeprom_pkg::ST_WR_DATA: begin
          if (r.bitcnt == eeprom_pkg::BITS_PER_BYTE) begin
            if (r.wp_s2) begin
              // R7: protected bytes are dropped
              n.drive_low = 1'b1;
              n.st = eeprom_pkg::ST_ACK_DATA;
            end else if (fifo_in_ready) begin
              // R8: normal write path
              // R2: queue each received byte
              push_c = 1'b1;
              // R14: wrap in page
              n.addr = page_inc(r.addr);
              n.drive_low = 1'b1;
              n.st = eeprom_pkg::ST_ACK_DATA;
            end else begin
              n.st = eeprom_pkg::ST_IDLE;
            end
          end
        end
        eeprom_pkg::ST_RD_DATA: begin
          if (r.bitcnt == eeprom_pkg::BITS_PER_BYTE) begin
            n.drive_low = 1'b0;
            n.mack = 1'b0;
            n.st = eeprom_pkg::ST_RD_ACK;
          end else begin
            // R9: pull low or release
            n.drive_low = !r.shift[7];
          end
        end
        eeprom_pkg::ST_RD_ACK: begin
          n.bitcnt = '0;
          if (r.mack) begin
            n.shift = rd_byte;
            n.addr = seq_inc(r.addr);
            n.drive_low = !rd_byte[7];
            n.st = eeprom_pkg::ST_RD_DATA;
          end else begin
            n.st = eeprom_pkg::ST_IDLE;
          end
        end
        default: begin
          n.drive_low = 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  // R4: reset clears state and idles
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  // R7: array write gated by protect
  // R3: bytes committed during programming
  always_ff @(posedge ref_clk) begin
    if (ce && drain_c && fifo_out_valid && !r.wp_s2) begin
      mem[fifo_out.addr] <= fifo_out.data;
    end
  end

  // ---------------------------------------------------------------------
  // Write queue
  // ---------------------------------------------------------------------
  // The queue holds twice a page, so an over-long page write still fits;
  // a byte that finds it full is refused and the transfer dropped.
  byte_fifo #(
    .WIDTH(eeprom_pkg::WR_ITEM_W),
    .DEPTH(eeprom_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .in_valid(push_c),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(drain_c),
    .out_data(fifo_out)
  );

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  // R9: open-drain data pin
  assign sda_out = r.sda_o;
  assign sda_oe = r.drive_low;
  assign busy = r.busy;

endmodule

// File: pkg/eeprom_pkg.sv
// Purpose: Shared constants and types of the two-wire serial memory slave.
// Assumes: A sampling clock of 125 MHz.
// Notes: The programming time count is also a parameter of the top module.
package eeprom_pkg;

  // ---------------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int MEM_BYTES = 256;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_W = 4;

  // ---------------------------------------------------------------------
  // Bus framing and buffering
  // ---------------------------------------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int FIFO_DEPTH = 32;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 125;
  localparam int PROG_TIME_US = 5000;
  // Longest time: rounded down, here exact.
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_FREQ_MHZ;
  localparam int PROG_CNT_W = 20;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DEV_ADDR = 4'h1,
    ST_ACK_DEV = 4'h2,
    ST_WORD_ADDR = 4'h3,
    ST_ACK_WORD = 4'h4,
    ST_WR_DATA = 4'h5,
    ST_ACK_DATA = 4'h6,
    ST_RD_DATA = 4'h7,
    ST_RD_ACK = 4'h8,
    ST_PROG = 4'h9
  } bus_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wr_item_t;

  localparam int WR_ITEM_W = ADDR_W + DATA_W;

endpackage

// File: verification/bus_master_model.sv
// Purpose: Behavioural two-wire bus master that frames and clocks transfers.
// Assumes: Tasks are called from the bench; changes land on clk rising edges.
// Notes: half_n sets each clock phase; raise it to run the bus slowly.
`timescale 1ns/1ps
module bus_master_model (
  // Clock
  input wire logic clk,
  // Two-wire bus
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  int half_n = 5;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic half();
    repeat (half_n) @(posedge clk);
  endtask
  // Start with clock high.
  // Data is released while the clock is low, so no false Stop.
  task automatic start();
    @(posedge clk);
    sda_pull <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_pull <= 1'b1;
    half();
    scl <= 1'b0;
    half();
  endtask
  task automatic stop();
    @(posedge clk);
    sda_pull <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_pull <= 1'b0;
    half();
  endtask
  // master clocks bits.
  // Data moves one cycle after the clock falls, so the slave sees a clean hold.
  task automatic bit_x(input logic b, output logic r);
    @(posedge clk);
    sda_pull <= ~b;
    repeat (half_n - 1) @(posedge clk);
    scl <= 1'b1;
    half();
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule

// File: verification/eeprom_monitor.sv
// Purpose: Concurrent checks on the ports of the serial memory slave.
// Assumes: Bound to every slave instance; bus timing as the master model makes it.
// Notes: The programming bound leaves room for the queue drain.
`timescale 1ns/1ps
module eeprom_monitor #(
  parameter int PROG_CYCLES = 200
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Bus and status
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_protect,
  input wire logic busy
);
  int busy_len_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy_len_r <= 0;
    end else begin
      busy_len_r <= busy ? busy_len_r + 1 : 0;
    end
  end
  a_pin_open_drain: assert property (
    @(posedge ref_clk) disable iff (!rstn) sda_out == 1'b0)
    else $error("Data pin driven high");
  a_ack_scl_low: assert property (
    @(posedge ref_clk) disable iff (!rstn) (sda_oe != $past(sda_oe)) |-> !scl)
    else $error("Data drive changed with clock high");
  a_ack_stands: assert property (
    @(posedge ref_clk) disable iff (!rstn) $rose(sda_oe) |-> sda_oe [*6])
    else $error("Data drive released too early");
  a_quiet_busy: assert property (
    @(posedge ref_clk) disable iff (!rstn) busy |-> !sda_oe)
    else $error("Bus answered while programming");
  a_busy_stop: assert property (
    @(posedge ref_clk) disable iff (!rstn) $rose(busy) |-> scl && sda_in)
    else $error("Programming began without Stop");
  a_protect_block: assert property (
    @(posedge ref_clk) disable iff (!rstn) $rose(busy) |-> !write_protect)
    else $error("Programming began while protected");
  a_prog_bound: assert property (
    @(posedge ref_clk) disable iff (!rstn) busy_len_r <= PROG_CYCLES + 40)
    else $error("Programming took too long");
  a_reset_quiet: assert property (
    @(posedge ref_clk) !rstn |-> ##1 (!sda_oe && !busy))
    else $error("Outputs active after reset");
endmodule

bind two_wire_eeprom_slave eeprom_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_monitor (
  .ref_clk(ref_clk), .rstn(rstn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .write_protect(write_protect), .busy(busy));

// File: verification/tb_top.sv
// Purpose: Self-checking bench for the serial memory slave.
// Assumes: Short programming count; random data from a fixed LFSR seed.
// Notes: Expected array contents are tracked in exp_mem.
`timescale 1ns/1ps
module tb_top;
  localparam int PROG_N = 200;
  // Type field of the select byte; the value is arbitrary.
  localparam logic [3:0] DEV_T = 4'h5;
  logic ref_clk = 1'b0;
  logic rstn = 1'b1;
  logic ce = 1'b1;
  logic wp_r = 1'b0;
  logic [2:0] sel_r = 3'h0;
  logic scl, sda_pull, sda, dut_oe, busy;
  logic [15:0] lfsr_r = 16'h65d4;
  logic [7:0] exp_mem [256];
  int n_mismatch = 0;
  int n_checks = 0;
  always #4 ref_clk = ~ref_clk;
  // Pull-up wins unless someone pulls low.
  assign sda = (dut_oe || sda_pull) ? 1'b0 : 1'b1;
  bus_master_model m (.clk(ref_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  two_wire_eeprom_slave #(.DEV_TYPE(DEV_T), .PROG_CYCLES(PROG_N)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .scl(scl), .sda_in(sda), .sda_out(),
    .sda_oe(dut_oe), .device_select_bit_0(sel_r[0]), .device_select_bit_1(sel_r[1]),
    .device_select_bit_2(sel_r[2]), .write_protect(wp_r), .busy(busy));
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] page_addr(input logic [7:0] a, input int i);
    return {a[7:4], a[3:0] + 4'(i)};
  endfunction
  task automatic rnd(output logic [7:0] v);
    lfsr_r = lfsr_step(lfsr_r);
    v = lfsr_r[7:0];
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    #1;
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic sel(input logic rw, input logic ack_exp);
    logic ack;
    m.start();
    m.wbyte({DEV_T, sel_r, rw}, ack);
    check(ack, ack_exp);
  endtask
  task automatic wr(input logic [7:0] a, input int n);
    logic ack;
    logic [7:0] d;
    sel(1'b0, 1'b1);
    m.wbyte(a, ack);
    check(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      rnd(d);
      m.wbyte(d, ack);
      check(ack, 1'b1);
      if (!wp_r) exp_mem[page_addr(a, i)] = d;
    end
    m.stop();
    check(busy, !wp_r);
    if (!wp_r) begin
      sel(1'b0, 1'b0);
      m.stop();
    end
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge ref_clk);
    check(busy, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    logic ack;
    logic [7:0] d;
    sel(1'b0, 1'b1);
    m.wbyte(a, ack);
    check(ack, 1'b1);
    sel(1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i == n - 1, d);
      check(d, exp_mem[8'(a + i)]);
    end
    m.stop();
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    logic [7:0] base;
    logic ack;
    rstn <= 1'b0;
    rnd(base);
    sel_r <= base[2:0];
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int k = 0; k < 3; k++) begin
      m.start();
      m.wbyte({DEV_T, sel_r ^ (3'h1 << k), 1'b0}, ack);
      check(ack, 1'b0);
      m.stop();
    end
    rnd(base);
    base[3:0] = 4'he;
    // Eighteen bytes from offset 14 wrap and overwrite the first two.
    wr(base, 18);
    wr({base[7:4], 4'h3}, 2);
    rd({base[7:4], 4'h0}, 16);
    wp_r <= 1'b1;
    // Protected write leaves the page as it was.
    wr({base[7:4], 4'h5}, 1);
    wp_r <= 1'b0;
    m.half_n = 7;
    rd({base[7:4], 4'h0}, 16);
    m.half_n = 5;
    sel(1'b0, 1'b1);
    fork
      m.wbyte(8'h00, ack);
      begin
        repeat (30) @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
      end
    join
    check(ack, 1'b0);
    check(dut_oe, 1'b0);
    m.stop();
    rd({base[7:4], 4'h8}, 2);
    stop_test();
  end
endmodule
